// file: core/char_class.sv
// character classifier: printable test and hex digit decode
`timescale 1ns/1ps
module char_class
  import terminal_active_check_pkg::*;
(
  input wire logic [7:0] ch_i,
  output logic printable_o,
  output logic hex_o,
  output logic [3:0] nibble_o
);
  logic is_dig;
  logic is_uc;
  logic is_lc;
  logic [7:0] val;

  always_comb begin
    printable_o = (ch_i >= CH_PRINT_LO) && (ch_i <= CH_PRINT_HI);
    is_dig = (ch_i >= CH_DIG_LO) && (ch_i <= CH_DIG_HI);
    is_uc = (ch_i >= CH_UC_A) && (ch_i <= CH_UC_F);
    is_lc = (ch_i >= CH_LC_A) && (ch_i <= CH_LC_F);
    hex_o = is_dig || is_uc || is_lc;
    if (is_dig) begin
      val = ch_i - CH_DIG_LO;
    end else if (is_uc) begin
      val = ch_i - CH_UC_A + HEX_ALPHA_BASE;
    end else if (is_lc) begin
      val = ch_i - CH_LC_A + HEX_ALPHA_BASE;
    end else begin
      val = 8'h00;
    end
    nibble_o = val[3:0];
  end
endmodule

// file: core/route_decode.sv
// bridge field, direction and unit decode for binary messages
`timescale 1ns/1ps
module route_decode
  import terminal_active_check_pkg::*;
(
  input wire logic [7:0] hdr1_i,
  input wire logic [7:0] hdr2_i,
  input wire logic inbound_i,
  output route_t route_o,
  output logic supported_o
);
  logic odd_fn;
  logic [1:0] lun;
  logic [1:0] bridge;

  always_comb begin
    odd_fn = hdr1_i[NETFN_LSB];
    lun = hdr1_i[LOW_MSB:LOW_LSB];
    bridge = hdr2_i[LOW_MSB:LOW_LSB];
    route_o = ROUTE_NONE;
    if (inbound_i) begin
      if (!odd_fn && bridge == BRIDGE_LOCAL) begin
        route_o = (lun == SMS_LUN) ? ROUTE_SMS : ROUTE_LOCAL;
      end
    end else if (odd_fn) begin
      if (bridge == BRIDGE_LOCAL) begin
        route_o = (lun == SMS_LUN) ? ROUTE_SMS : ROUTE_LOCAL;
      end else if (bridge == BRIDGE_ASYNC) begin
        route_o = ROUTE_BRIDGED;
      end
    end
    supported_o = (route_o != ROUTE_NONE);
  end
endmodule

// file: core/terminal_active_check_parser.sv
// terminal mode message framer, editor and hex-ASCII decoder
// Operation
// - messages are bracketed and closed by the input newline sequence
// - characters before a start bracket are dropped
// - text prefix case-sensitive; hex digits in either case
// - at most 122 characters including both brackets
// - only printable ASCII is legal content
// - abort key drops message; with line editing, newline echoes newline
// - backspace or erase key removes last unsubmitted character
// - continuation character plus newline joins the next line
// - illegal character clears message and returns to hunting
// - binary command is hex pairs, optionally single-space separated
// - remote console implied software identifier 47h, unit 00b
// - request: netfn even and unit, sequence and bridge, command, data
// - response: odd netfn, command, completion code, then data
// - text commands have the prefix and no bridge or sequence fields
// - bridging only for hex commands by bridge, type, direction, unit
// - host software traffic uses unit 10b with bridge 00b
// - inbound bridge 00b units 00b 01b 11b go to local functions
// - inbound bridge 00b unit 10b queued to host software
// - no other inbound bridge, type, direction, unit combination is supported
// - session must be active before most commands are accepted
// - lowest-privilege commands accepted before a session exists
`timescale 1ns/1ps
module terminal_active_check_parser
  import terminal_active_check_pkg::*;
#(
  parameter int MAX_CHARS = MAX_MSG_CHARS,
  parameter logic [5:0] PRE_SESSION_NETFN = 6'h00
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  input wire logic line_edit_en_i,
  input wire nl_mode_t nl_mode_i,
  input wire logic session_active_i,
  input wire logic resp_valid_i,
  input wire logic [7:0] resp_hdr1_i,
  input wire logic [7:0] resp_hdr2_i,
  output logic rx_ready_o,
  output logic newline_out_o,
  output logic [7:0] msg_data_o,
  output logic msg_valid_o,
  output logic msg_done_o,
  output logic msg_text_o,
  output status_t msg_status_o,
  output route_t msg_route_o,
  output logic [7:0] msg_hdr1_o,
  output logic [7:0] msg_hdr2_o,
  output logic [7:0] msg_cmd_o,
  output logic [7:0] req_software_identifier_o,
  output logic [1:0] req_lun_o,
  output logic resp_done_o,
  output logic resp_ok_o,
  output route_t resp_route_o
);
  localparam int DEPTH = MAX_CHARS - BRACKET_CHARS;
  localparam int CW = $clog2(DEPTH + 1);

  if (MAX_CHARS < MIN_SYS_CHARS + BRACKET_CHARS || MAX_CHARS > 256) begin : g_bad_len
    $error("MAX_CHARS out of range");
  end

  typedef enum logic [2:0] {S_HUNT, S_COLLECT, S_STOP_NL, S_CONT_NL, S_ESC_NL, S_DRAIN,
                            S_FINISH} state_t;

  state_t state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d, rd_q, rd_d, nbytes_q, nbytes_d;
  logic cr_q, cr_d, lo_q, lo_d, sep_q, sep_d, bad_q, bad_d, text_q, text_d;
  logic pre_q, pre_d;
  logic [3:0] hi_q, hi_d;
  logic [7:0] hdr1_q, hdr1_d, hdr2_q, hdr2_d, cmd_q, cmd_d;
  logic [7:0] buf_q [DEPTH];
  logic wr_en;
  logic [CW-1:0] wr_idx;
  logic [7:0] data_q, data_d;
  logic valid_q, valid_d, done_q, done_d, nlo_q, nlo_d, ready_q, ready_d;
  logic mtext_q, mtext_d;
  status_t stat_q, stat_d;
  route_t route_q, route_d, rroute_q;
  logic [7:0] mh1_q, mh1_d, mh2_q, mh2_d, mcmd_q, mcmd_d;
  logic rdone_q, rok_q;
  logic [7:0] software_identifier_q;
  logic [1:0] lun_q;

  logic fire, rx_print, rx_hex, rd_print, rd_hex, nl_done, nl_part, in_ok, out_ok;
  logic [3:0] rx_nib, rd_nib;
  logic [7:0] rd_ch;
  logic last_cont, at_last;
  route_t in_route, out_route;

  assign fire = rx_valid_i && ready_q;
  assign rd_ch = buf_q[rd_q];
  assign at_last = (rd_q == cnt_q - CW'(1));
  assign last_cont = (cnt_q != '0) && (buf_q[cnt_q - CW'(1)] == CH_CONT);

  char_class u_rx_class (
    .ch_i(rx_data_i),
    .printable_o(rx_print),
    .hex_o(rx_hex),
    .nibble_o(rx_nib)
  );

  char_class u_rd_class (
    .ch_i(rd_ch),
    .printable_o(rd_print),
    .hex_o(rd_hex),
    .nibble_o(rd_nib)
  );

  route_decode u_in_route (
    .hdr1_i(hdr1_q),
    .hdr2_i(hdr2_q),
    .inbound_i(1'b1),
    .route_o(in_route),
    .supported_o(in_ok)
  );

  route_decode u_out_route (
    .hdr1_i(resp_hdr1_i),
    .hdr2_i(resp_hdr2_i),
    .inbound_i(1'b0),
    .route_o(out_route),
    .supported_o(out_ok)
  );

  // newline sequence per configured input mode
  always_comb begin
    nl_part = (nl_mode_i == NL_CRLF) && (rx_data_i == CH_CR);
    nl_done = ((nl_mode_i == NL_CR) && (rx_data_i == CH_CR)) ||
              ((nl_mode_i == NL_LF) && (rx_data_i == CH_LF)) ||
              ((nl_mode_i == NL_CRLF) && (rx_data_i == CH_LF) && cr_q);
  end

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    rd_d = rd_q;
    nbytes_d = nbytes_q;
    cr_d = fire ? nl_part : cr_q;
    lo_d = lo_q;
    sep_d = sep_q;
    bad_d = bad_q;
    text_d = text_q;
    pre_d = pre_q;
    hi_d = hi_q;
    hdr1_d = hdr1_q;
    hdr2_d = hdr2_q;
    cmd_d = cmd_q;
    wr_en = 1'b0;
    wr_idx = cnt_q;
    data_d = data_q;
    valid_d = 1'b0;
    done_d = 1'b0;
    nlo_d = 1'b0;
    mtext_d = mtext_q;
    stat_d = stat_q;
    route_d = route_q;
    mh1_d = mh1_q;
    mh2_d = mh2_q;
    mcmd_d = mcmd_q;
    case (state_q)
      S_HUNT: begin
        // drop everything but a start bracket
        if (fire && rx_data_i == CH_START) begin
          cnt_d = '0;
          state_d = S_COLLECT;
        end
      end
      S_COLLECT: begin
        if (fire) begin
          if (rx_data_i == CH_ABORT) begin
            state_d = line_edit_en_i ? S_ESC_NL : S_HUNT;
          end else if (rx_data_i == CH_BACKSPACE || rx_data_i == CH_ERASE) begin
            if (cnt_q != '0) begin
              cnt_d = cnt_q - CW'(1);
            end
          end else if (last_cont && (nl_done || nl_part)) begin
            // join next line, drop the continuation mark
            if (nl_done) begin
              cnt_d = cnt_q - CW'(1);
            end else begin
              state_d = S_CONT_NL;
            end
          end else if (!rx_print) begin
            state_d = S_HUNT;
          end else if (rx_data_i == CH_STOP) begin
            state_d = S_STOP_NL;
          end else if (cnt_q == CW'(DEPTH)) begin
            state_d = S_HUNT;
          end else begin
            wr_en = 1'b1;
            cnt_d = cnt_q + CW'(1);
          end
        end
      end
      S_CONT_NL: begin
        if (fire) begin
          // second half of a two-character newline
          if (nl_done) begin
            cnt_d = cnt_q - CW'(1);
            state_d = S_COLLECT;
          end else begin
            state_d = S_HUNT;
          end
        end
      end
      S_STOP_NL: begin
        if (fire) begin
          if (rx_data_i == CH_ABORT) begin
            state_d = line_edit_en_i ? S_ESC_NL : S_HUNT;
          end else if (rx_data_i == CH_BACKSPACE || rx_data_i == CH_ERASE) begin
            // stop bracket taken back, not yet submitted
            state_d = S_COLLECT;
          end else if (nl_done) begin
            rd_d = '0;
            nbytes_d = '0;
            lo_d = 1'b0;
            sep_d = 1'b0;
            bad_d = (cnt_q == '0);
            hdr1_d = 8'h00;
            hdr2_d = 8'h00;
            cmd_d = 8'h00;
            text_d = (cnt_q >= CW'(MIN_SYS_CHARS)) && (buf_q[0] == CH_PFX0) &&
                     (buf_q[1] == CH_PFX1) && (buf_q[2] == CH_PFX2);
            // login and no-op commands before a session
            pre_d = (buf_q[PFX_CMD_POS] == CH_PWD) || (buf_q[PFX_CMD_POS] == CH_TERMINAL_ACTIVE_CHECK);
            state_d = (cnt_q == '0) ? S_FINISH : S_DRAIN;
          end else if (!nl_part) begin
            state_d = S_HUNT;
          end
        end
      end
      S_ESC_NL: begin
        if (fire) begin
          // newline after abort answers with output newline
          if (nl_done) begin
            nlo_d = 1'b1;
            state_d = S_HUNT;
          end else if (!nl_part) begin
            state_d = S_HUNT;
          end
        end
      end
      S_DRAIN: begin
        rd_d = rd_q + CW'(1);
        if (text_q) begin
          data_d = rd_ch;
          valid_d = 1'b1;
        end else if (!lo_q) begin
          // high digit, or one space between pairs
          if (rd_hex) begin
            hi_d = rd_nib;
            lo_d = 1'b1;
            sep_d = 1'b0;
          end else if (rd_ch == CH_SPACE && nbytes_q != '0 && !sep_q) begin
            sep_d = 1'b1;
          end else begin
            bad_d = 1'b1;
          end
        end else if (rd_hex) begin
          data_d = {hi_q, rd_nib};
          valid_d = 1'b1;
          lo_d = 1'b0;
          nbytes_d = nbytes_q + CW'(1);
          if (nbytes_q == CW'(0)) begin
            hdr1_d = {hi_q, rd_nib};
          end else if (nbytes_q == CW'(1)) begin
            hdr2_d = {hi_q, rd_nib};
          end else if (nbytes_q == CW'(2)) begin
            cmd_d = {hi_q, rd_nib};
          end
        end else begin
          bad_d = 1'b1;
        end
        if (at_last || bad_d) begin
          state_d = S_FINISH;
        end
      end
      S_FINISH: begin
        done_d = 1'b1;
        mtext_d = text_q;
        mh1_d = text_q ? 8'h00 : hdr1_q;
        mh2_d = text_q ? 8'h00 : hdr2_q;
        mcmd_d = text_q ? 8'h00 : cmd_q;
        // text commands never route through the bridge
        route_d = text_q ? ROUTE_NONE : in_route;
        if (!text_q && (bad_q || lo_q || sep_q || nbytes_q < CW'(MIN_HEX_BYTES))) begin
          stat_d = ST_MALFORMED;
        end else if (!text_q && !in_ok) begin
          stat_d = ST_UNSUPPORTED;
        end else if (!session_active_i && !(text_q ? pre_q :
                     (hdr1_q[NETFN_MSB:NETFN_LSB] == PRE_SESSION_NETFN))) begin
          stat_d = ST_NO_SESSION;
        end else begin
          stat_d = ST_OK;
        end
        state_d = S_HUNT;
      end
      default: begin
        state_d = S_HUNT;
      end
    endcase
    // input is held off while a submitted message drains
    ready_d = (state_d != S_DRAIN) && (state_d != S_FINISH);
  end

  always_ff @(posedge clock_i) begin
    if (wr_en) begin
      buf_q[wr_idx] <= rx_data_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_q <= S_HUNT;
      cnt_q <= '0;
      rd_q <= '0;
      nbytes_q <= '0;
      cr_q <= 1'b0;
      lo_q <= 1'b0;
      sep_q <= 1'b0;
      bad_q <= 1'b0;
      text_q <= 1'b0;
      pre_q <= 1'b0;
      hi_q <= 4'h0;
      hdr1_q <= 8'h00;
      hdr2_q <= 8'h00;
      cmd_q <= 8'h00;
      data_q <= 8'h00;
      valid_q <= 1'b0;
      done_q <= 1'b0;
      nlo_q <= 1'b0;
      ready_q <= 1'b0;
      mtext_q <= 1'b0;
      stat_q <= ST_OK;
      route_q <= ROUTE_NONE;
      mh1_q <= 8'h00;
      mh2_q <= 8'h00;
      mcmd_q <= 8'h00;
      rdone_q <= 1'b0;
      rok_q <= 1'b0;
      rroute_q <= ROUTE_NONE;
      software_identifier_q <= RC_SOFTWARE_ID;
      lun_q <= RC_LUN;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      rd_q <= rd_d;
      nbytes_q <= nbytes_d;
      cr_q <= cr_d;
      lo_q <= lo_d;
      sep_q <= sep_d;
      bad_q <= bad_d;
      text_q <= text_d;
      pre_q <= pre_d;
      hi_q <= hi_d;
      hdr1_q <= hdr1_d;
      hdr2_q <= hdr2_d;
      cmd_q <= cmd_d;
      data_q <= data_d;
      valid_q <= valid_d;
      done_q <= done_d;
      nlo_q <= nlo_d;
      ready_q <= ready_d;
      mtext_q <= mtext_d;
      stat_q <= stat_d;
      route_q <= route_d;
      mh1_q <= mh1_d;
      mh2_q <= mh2_d;
      mcmd_q <= mcmd_d;
      // outbound header check, one cycle later
      rdone_q <= resp_valid_i;
      rok_q <= resp_valid_i && out_ok;
      rroute_q <= resp_valid_i ? out_route : rroute_q;
      // implied remote console identity held in flops
      software_identifier_q <= RC_SOFTWARE_ID;
      lun_q <= RC_LUN;
    end
  end

  assign rx_ready_o = ready_q;
  assign newline_out_o = nlo_q;
  assign msg_data_o = data_q;
  assign msg_valid_o = valid_q;
  assign msg_done_o = done_q;
  assign msg_text_o = mtext_q;
  assign msg_status_o = stat_q;
  assign msg_route_o = route_q;
  assign msg_hdr1_o = mh1_q;
  assign msg_hdr2_o = mh2_q;
  assign msg_cmd_o = mcmd_q;
  // implied remote console identity, registered outputs
  assign req_software_identifier_o = software_identifier_q;
  assign req_lun_o = lun_q;
  assign resp_done_o = rdone_q;
  assign resp_ok_o = rok_q;
  assign resp_route_o = rroute_q;
endmodule

// file: core/terminal_active_check_pkg.sv
// shared constants and types for the terminal mode message parser
package terminal_active_check_pkg;
  localparam int MAX_MSG_CHARS = 122;
  localparam int BRACKET_CHARS = 2;
  localparam int MIN_HEX_BYTES = 3;
  localparam int MIN_SYS_CHARS = 5;

  localparam logic [7:0] CH_START = 8'h5b;
  localparam logic [7:0] CH_STOP = 8'h5d;
  localparam logic [7:0] CH_ABORT = 8'h1b;
  localparam logic [7:0] CH_BACKSPACE = 8'h08;
  localparam logic [7:0] CH_ERASE = 8'h7f;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_CONT = 8'h5c;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_PRINT_LO = 8'h20;
  localparam logic [7:0] CH_PRINT_HI = 8'h7e;
  localparam logic [7:0] CH_DIG_LO = 8'h30;
  localparam logic [7:0] CH_DIG_HI = 8'h39;
  localparam logic [7:0] CH_UC_A = 8'h41;
  localparam logic [7:0] CH_UC_F = 8'h46;
  localparam logic [7:0] CH_LC_A = 8'h61;
  localparam logic [7:0] CH_LC_F = 8'h66;
  localparam logic [7:0] HEX_ALPHA_BASE = 8'h0a;
  // text command prefix and the two commands usable before login
  localparam logic [7:0] CH_PFX0 = 8'h53;
  localparam logic [7:0] CH_PFX1 = 8'h59;
  localparam logic [7:0] CH_PFX2 = 8'h53;
  localparam logic [7:0] CH_PWD = 8'h50;
  localparam logic [7:0] CH_TERMINAL_ACTIVE_CHECK = 8'h54;
  localparam int PFX_CMD_POS = 4;

  localparam int NETFN_MSB = 7;
  localparam int NETFN_LSB = 2;
  localparam int LOW_MSB = 1;
  localparam int LOW_LSB = 0;
  localparam logic [7:0] RC_SOFTWARE_ID = 8'h47;
  localparam logic [1:0] RC_LUN = 2'b00;
  localparam logic [1:0] SMS_LUN = 2'b10;
  localparam logic [1:0] BRIDGE_LOCAL = 2'b00;
  localparam logic [1:0] BRIDGE_ASYNC = 2'b01;

  typedef enum logic [1:0] {NL_CR, NL_LF, NL_CRLF} nl_mode_t;
  typedef enum logic [1:0] {ROUTE_NONE, ROUTE_LOCAL, ROUTE_SMS, ROUTE_BRIDGED} route_t;
  typedef enum logic [1:0] {ST_OK, ST_MALFORMED, ST_UNSUPPORTED, ST_NO_SESSION} status_t;
endpackage

// file: verification/console_model.sv
// remote console model that types characters into the parser
`timescale 1ns/1ps
module console_model (
  input wire logic clock_i,
  input wire logic rx_ready_i,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic stuck_o
);
  initial begin
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
    stuck_o = 1'b0;
  end
  // framing, length and pairs come from the caller
  task automatic type_str(input string s, input int gap);
    int n;
    for (int i = 0; i < s.len(); i++) begin
      @(negedge clock_i);
      rx_data_o = s[i];
      rx_valid_o = 1'b1;
      n = 0;
      do begin
        @(posedge clock_i);
        n++;
      end while (rx_ready_i !== 1'b1 && n < 500);
      if (n >= 500) stuck_o = 1'b1;
      if (gap > 0 || i == s.len() - 1) begin
        // idle line shows inverted data so stale bytes never match
        @(negedge clock_i);
        rx_valid_o = 1'b0;
        rx_data_o = ~rx_data_o;
        repeat (gap) @(posedge clock_i);
      end
    end
  endtask
endmodule

// file: verification/tb.sv
// self-checking bench for the terminal mode message parser
`timescale 1ns/1ps
module tb;
  import terminal_active_check_pkg::*;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic edit = 1'b1;
  logic sess = 1'b1;
  logic rv = 1'b0;
  nl_mode_t nlm = NL_CR;
  logic [7:0] h1 = 8'h00;
  logic [7:0] h2 = 8'h00;
  logic [7:0] rxd, md, mh1, mh2, mc, software_identifier;
  logic rxv, stuck, rdy, nlo, mv, mdn, mtxt, rdn, rok;
  logic [1:0] rlun;
  status_t mst;
  route_t mrt, rrt;
  logic [7:0] got[$];
  int dones = 0;
  int nls = 0;
  int gap = 0;
  int errors = 0;
  int samples_checked = 0;
  string s;
  logic [7:0] th1[5] = '{8'h1c, 8'h1e, 8'h1d, 8'h18, 8'h1c};
  logic [7:0] th2[5] = '{8'h00, 8'h00, 8'h05, 8'h00, 8'h02};
  route_t trt[5] = '{ROUTE_LOCAL, ROUTE_SMS, ROUTE_BRIDGED, ROUTE_NONE, ROUTE_NONE};

  always #2 clock_i = ~clock_i;

  terminal_active_check_parser terminal_active_check_parser_i (.clock_i(clock_i), .srst_i(srst_i), .rx_data_i(rxd),
    .rx_valid_i(rxv), .line_edit_en_i(edit), .nl_mode_i(nlm), .session_active_i(sess),
    .resp_valid_i(rv), .resp_hdr1_i(h1), .resp_hdr2_i(h2), .rx_ready_o(rdy),
    .newline_out_o(nlo), .msg_data_o(md), .msg_valid_o(mv), .msg_done_o(mdn),
    .msg_text_o(mtxt), .msg_status_o(mst), .msg_route_o(mrt), .msg_hdr1_o(mh1),
    .msg_hdr2_o(mh2), .msg_cmd_o(mc), .req_software_identifier_o(software_identifier), .req_lun_o(rlun),
    .resp_done_o(rdn), .resp_ok_o(rok), .resp_route_o(rrt));
  console_model console_model_i (.clock_i(clock_i), .rx_ready_i(rdy), .rx_data_o(rxd),
    .rx_valid_o(rxv), .stuck_o(stuck));

  // pulses stand one cycle, so each is counted once per edge
  always @(posedge clock_i) begin
    if (mv === 1'b1) got.push_back(md);
    if (mdn === 1'b1) dones++;
    if (nlo === 1'b1) nls++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic put(input string t);
    console_model_i.type_str(t, gap);
    if (stuck === 1'b1) begin
      errors++;
      conclude();
    end
  endtask

  task automatic msg(input string t, input status_t st, input route_t rt, input int nb,
                     input logic [23:0] f3, input logic txt);
    int d0, n;
    d0 = dones;
    got.delete();
    put(t);
    n = 0;
    while (dones == d0 && n < 400) begin
      @(negedge clock_i);
      n++;
    end
    if (n >= 400) begin
      errors++;
      conclude();
    end
    check(mst, st);
    check(mtxt, txt);
    if (st == ST_OK && !txt) check(mrt, rt);
    if (st == ST_OK && !txt) check({mh1, mh2, mc}, f3);
    if (nb > 0) check(got.size(), nb);
    if (nb > 0 && got.size() >= 3) check({got[0], got[1], got[2]}, f3);
  endtask

  // no message may come out of a dropped one
  task automatic none(input string t);
    int d0;
    d0 = dones;
    put(t);
    repeat (140) @(negedge clock_i);
    check(dones - d0, 0);
  endtask

  initial begin
    repeat (2) @(negedge clock_i);
    srst_i = 1'b0;
    check({software_identifier, 6'h00, rlun}, 16'h4700);
    msg("[18 00 22]\015", ST_OK, ROUTE_LOCAL, 3, 24'h180022, 0);
    msg("xy]\033[1a0022]\015", ST_OK, ROUTE_SMS, 3, 24'h1a0022, 0);
    msg("[1C 00 22]\015", ST_UNSUPPORTED, ROUTE_NONE, 0, 0, 0);
    msg("[18 01 22]\015", ST_UNSUPPORTED, ROUTE_NONE, 0, 0, 0);
    msg("[18  00 22]\015", ST_MALFORMED, ROUTE_NONE, 0, 0, 0);
    msg("[18 0 22]\015", ST_MALFORMED, ROUTE_NONE, 0, 0, 0);
    msg("[18 00]\015", ST_MALFORMED, ROUTE_NONE, 0, 0, 0);
    gap = 3;
    msg("[18 0G\0100 2Z\1772]\015", ST_OK, ROUTE_LOCAL, 3, 24'h180022, 0);
    gap = 0;
    msg("[18 00 225]\010\010]\015", ST_OK, ROUTE_LOCAL, 3, 24'h180022, 0);
    msg("[18 00\\\015 22]\015", ST_OK, ROUTE_LOCAL, 3, 24'h180022, 0);
    msg("[\123\131\123\\\015 TEST]\015", ST_OK, ROUTE_NONE, 8, 24'h535953, 1);
    msg("[sys TEST]\015", ST_MALFORMED, ROUTE_NONE, 0, 0, 0);
    sess = 1'b0;
    msg("[18 00 22]\015", ST_NO_SESSION, ROUTE_NONE, 0, 0, 0);
    msg("[00 00 22]\015", ST_OK, ROUTE_LOCAL, 3, 24'h000022, 0);
    msg("[\123\131\123 TEST]\015", ST_OK, ROUTE_NONE, 8, 24'h535953, 1);
    msg("[\123\131\123 SET]\015", ST_NO_SESSION, ROUTE_NONE, 0, 0, 1);
    sess = 1'b1;
    none("[18 00 22\200]\015");
    none("[18 00\015 22]\015");
    s = "[\123\131\123 T";
    while (s.len() < MAX_MSG_CHARS - 1) s = {s, "A"};
    msg({s, "]\015"}, ST_OK, ROUTE_NONE, MAX_MSG_CHARS - 2, 24'h535953, 1);
    none({s, "A]\015"});
    nls = 0;
    none("[18 0\033\015");
    check(nls, 1);
    edit = 1'b0;
    none("[18 0\033\015");
    check(nls, 1);
    msg("[18\033[18 00 22]\015", ST_OK, ROUTE_LOCAL, 3, 24'h180022, 0);
    nlm = NL_LF;
    msg("[18 00 22]\012", ST_OK, ROUTE_LOCAL, 3, 24'h180022, 0);
    nlm = NL_CRLF;
    msg("[18 00 22]\015\012", ST_OK, ROUTE_LOCAL, 3, 24'h180022, 0);
    // response headers: local, host software, bridged, even netfn, bad bridge
    for (int i = 0; i < 5; i++) begin
      @(negedge clock_i);
      h1 = th1[i];
      h2 = th2[i];
      rv = 1'b1;
      @(negedge clock_i);
      rv = 1'b0;
      check(rdn, 1'b1);
      check(rok, i < 3);
      if (i < 3) check(rrt, trt[i]);
    end
    conclude();
  end
endmodule

// file: verification/terminal_active_check_parser_chk.sv
// assertion checker for the terminal mode message parser
`timescale 1ns/1ps
module terminal_active_check_parser_chk
  import terminal_active_check_pkg::*;
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic line_edit_en_i,
  input wire logic resp_valid_i,
  input wire logic [7:0] resp_hdr1_i,
  input wire logic [7:0] resp_hdr2_i,
  input wire logic rx_ready_o,
  input wire logic newline_out_o,
  input wire logic msg_valid_o,
  input wire logic msg_done_o,
  input wire logic msg_text_o,
  input wire status_t msg_status_o,
  input wire route_t msg_route_o,
  input wire logic [7:0] msg_hdr1_o,
  input wire logic [7:0] msg_hdr2_o,
  input wire logic [7:0] msg_cmd_o,
  input wire logic [7:0] req_software_identifier_o,
  input wire logic [1:0] req_lun_o,
  input wire logic resp_done_o,
  input wire logic resp_ok_o,
  input wire route_t resp_route_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  logic bin_ok;
  assign bin_ok = msg_done_o && msg_status_o == ST_OK && !msg_text_o;
  reset_quiet_a: assert property (
    $fell(srst_i) |-> !rx_ready_o && !msg_valid_o && !msg_done_o ##1 rx_ready_o)
    else $error("parser not quiet after reset");
  resp_pulse_a: assert property (
    resp_valid_i |=> resp_done_o) else $error("response check not answered");
  resp_ok_a: assert property (
    resp_done_o |-> resp_ok_o == ($past(resp_hdr1_i[2]) && !$past(resp_hdr2_i[1])))
    else $error("response verdict wrong");
  resp_route_a: assert property (
    resp_done_o && resp_ok_o |-> resp_route_o == ($past(resp_hdr2_i[0]) ? ROUTE_BRIDGED :
      $past(resp_hdr1_i[1:0]) == SMS_LUN ? ROUTE_SMS : ROUTE_LOCAL))
    else $error("response route wrong");
  fixed_id_a: assert property (
    req_software_identifier_o == RC_SOFTWARE_ID && req_lun_o == RC_LUN) else $error("console id wrong");
  drain_a: assert property (
    msg_valid_o |-> !rx_ready_o) else $error("input open while draining");
  local_hdr_a: assert property (
    bin_ok |-> !msg_hdr1_o[NETFN_LSB] && msg_hdr2_o[1:0] == BRIDGE_LOCAL)
    else $error("accepted request header wrong");
  sms_route_a: assert property (
    bin_ok |-> (msg_route_o == ROUTE_SMS) == (msg_hdr1_o[1:0] == SMS_LUN))
    else $error("host software route wrong");
  text_hdr_a: assert property (
    msg_done_o && msg_text_o |-> {msg_hdr1_o, msg_hdr2_o, msg_cmd_o} == 24'h000000)
    else $error("text message has header fields");
  edit_nl_a: assert property (
    newline_out_o |-> $past(line_edit_en_i)) else $error("newline echo without editing");
  cover property (bin_ok && msg_route_o == ROUTE_SMS);
  cover property (newline_out_o);
  cover property (resp_done_o && resp_ok_o && resp_route_o == ROUTE_BRIDGED);
endmodule

bind terminal_active_check_parser terminal_active_check_parser_chk chk_i (.clock_i(clock_i), .srst_i(srst_i),
  .line_edit_en_i(line_edit_en_i), .resp_valid_i(resp_valid_i), .resp_hdr1_i(resp_hdr1_i),
  .resp_hdr2_i(resp_hdr2_i), .rx_ready_o(rx_ready_o), .newline_out_o(newline_out_o),
  .msg_valid_o(msg_valid_o), .msg_done_o(msg_done_o), .msg_text_o(msg_text_o),
  .msg_status_o(msg_status_o), .msg_route_o(msg_route_o), .msg_hdr1_o(msg_hdr1_o),
  .msg_hdr2_o(msg_hdr2_o), .msg_cmd_o(msg_cmd_o), .req_software_identifier_o(req_software_identifier_o),
  .req_lun_o(req_lun_o), .resp_done_o(resp_done_o), .resp_ok_o(resp_ok_o),
  .resp_route_o(resp_route_o));
